// *** tap_pkg.sv ***
package tap_pkg;
  // ****************************************************************
  // instruction opcodes and id code layout
  // ****************************************************************
  localparam int          IR_WIDTH       = 3;
  localparam logic [2:0]  OP_EXTEST      = 3'h0;
  localparam logic [2:0]  OP_IDCODE      = 3'h1;
  localparam logic [2:0]  OP_SAMPLE      = 3'h2;
  localparam logic [2:0]  OP_CLAMP       = 3'h3;
  localparam logic [2:0]  OP_HIGHZ       = 3'h4;
  localparam logic [2:0]  OP_BYPASS      = 3'h7;
  localparam logic [2:0]  IR_CAPTURE     = 3'h1;
  localparam int          ID_WIDTH       = 32;
  localparam int          ID_MFR_LSB     = 1;
  localparam int          ID_DEV_LSB     = 12;
  localparam int          ID_VER_LSB     = 28;
  localparam int          BSR_LEN_RESET  = 8;
  localparam int          SYNC_STAGES    = 2;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
    ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } tap_state_e;
endpackage : tap_pkg

// *** bit_sync.sv ***
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  initial begin
    if (WIDTH < 1) $error("bit_sync width must be positive");
  end

  // first stage feeds only the second
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : bit_sync

// *** jtag_test_data_registers.sv ***
`timescale 1ns/1ps
module jtag_test_data_registers #(
  parameter int          BSR_LEN     = tap_pkg::BSR_LEN_RESET,
  // arbitrary neutral identity values
  parameter logic [10:0] MFR_CODE    = 11'h155,
  parameter logic [15:0] DEVICE_CODE = 16'h1234,
  parameter logic [3:0]  VERSION     = 4'h1
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               test_clock,
  input  wire logic               test_mode_select,
  input  wire logic               test_data_in,
  input  wire logic               test_async_reset_n,
  output logic                    test_data_out,
  output logic                    test_data_out_en,
  input  wire logic [BSR_LEN-1:0] bsr_capture,
  output logic      [BSR_LEN-1:0] bsr_parallel,
  output logic [2:0]              instruction,
  output logic                    pins_drive_bsr,
  output logic                    pins_highz
);
  // ****************************************************************
  // synchronise pins and find test clock edges
  // ****************************************************************
  logic [3:0] sync_w;
  logic       tck_prev_reg;
  logic       trst_n_s;

  initial begin
    if (BSR_LEN < 1) $error("boundary register needs at least one cell");
  end

  bit_sync #(.WIDTH(4)) u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in ({test_async_reset_n, test_clock, test_mode_select, test_data_in}),
    .sync_out (sync_w)
  );

  wire tdi_s = sync_w[0];
  wire tms_s = sync_w[1];
  wire tck_s = sync_w[2];
  assign trst_n_s = sync_w[3];
  wire tck_rise = tck_s & ~tck_prev_reg;
  wire tck_fall = ~tck_s & tck_prev_reg;

  // ****************************************************************
  // tap controller
  // ****************************************************************
  tap_pkg::tap_state_e state_reg, state_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tap_pkg::ST_RESET:    state_next = tms_s ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE;
      tap_pkg::ST_IDLE:     state_next = tms_s ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
      tap_pkg::ST_SEL_DR:   state_next = tms_s ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
      tap_pkg::ST_CAP_DR:   state_next = tms_s ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
      tap_pkg::ST_SHIFT_DR: state_next = tms_s ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
      tap_pkg::ST_EXIT1_DR: state_next = tms_s ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PAUSE_DR;
      tap_pkg::ST_PAUSE_DR: state_next = tms_s ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR;
      tap_pkg::ST_EXIT2_DR: state_next = tms_s ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SHIFT_DR;
      tap_pkg::ST_UPD_DR:   state_next = tms_s ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
      tap_pkg::ST_SEL_IR:   state_next = tms_s ? tap_pkg::ST_RESET : tap_pkg::ST_CAP_IR;
      tap_pkg::ST_CAP_IR:   state_next = tms_s ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
      tap_pkg::ST_SHIFT_IR: state_next = tms_s ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
      tap_pkg::ST_EXIT1_IR: state_next = tms_s ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PAUSE_IR;
      tap_pkg::ST_PAUSE_IR: state_next = tms_s ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR;
      tap_pkg::ST_EXIT2_IR: state_next = tms_s ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SHIFT_IR;
      tap_pkg::ST_UPD_IR:   state_next = tms_s ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
      default:              state_next = tap_pkg::ST_RESET;
    endcase
  end

  // ****************************************************************
  // data path selection
  // ****************************************************************
  logic [2:0]               ir_shift_reg;
  logic [tap_pkg::ID_WIDTH-1:0] id_shift_reg;
  logic [tap_pkg::ID_WIDTH-1:0] id_hold_reg;
  logic                     bypass_reg;
  logic [BSR_LEN-1:0]       bsr_shift_reg;

  wire [tap_pkg::ID_WIDTH-1:0] id_value = {VERSION, DEVICE_CODE, MFR_CODE, 1'b1};

  wire sel_bsr = (instruction == tap_pkg::OP_EXTEST) || (instruction == tap_pkg::OP_SAMPLE);
  wire sel_id  = (instruction == tap_pkg::OP_IDCODE) || (state_reg == tap_pkg::ST_RESET);
  wire sel_byp = !sel_bsr && !sel_id;

  wire in_shift_dr = (state_reg == tap_pkg::ST_SHIFT_DR);
  wire in_shift_ir = (state_reg == tap_pkg::ST_SHIFT_IR);
  wire dr_serial   = sel_id  ? id_shift_reg[0] :
                     sel_bsr ? bsr_shift_reg[0] : bypass_reg;
  wire tdo_next    = in_shift_ir ? ir_shift_reg[0] : dr_serial;
  wire tdo_en_next = in_shift_ir || in_shift_dr;
  wire tap_reset   = !trst_n_s;

  // ****************************************************************
  // controller and registers on test clock edges
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg    <= tap_pkg::ST_RESET;
      tck_prev_reg <= 1'b0;
    end else begin
      tck_prev_reg <= tck_s;
      if (tap_reset) state_reg <= tap_pkg::ST_RESET;
      else if (tck_rise) state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ir_shift_reg  <= tap_pkg::IR_CAPTURE;
      bypass_reg    <= 1'b0;
      bsr_shift_reg <= '0;
      id_shift_reg  <= '0;
    end else if (tck_rise) begin
      if (state_reg == tap_pkg::ST_CAP_IR) ir_shift_reg <= tap_pkg::IR_CAPTURE;
      else if (in_shift_ir) ir_shift_reg <= {tdi_s, ir_shift_reg[2:1]};
      if (sel_byp && state_reg == tap_pkg::ST_CAP_DR) bypass_reg <= 1'b0;
      else if (sel_byp && in_shift_dr) bypass_reg <= tdi_s;
      if (sel_bsr && state_reg == tap_pkg::ST_CAP_DR) bsr_shift_reg <= bsr_capture;
      else if (sel_bsr && in_shift_dr) bsr_shift_reg <= {tdi_s, bsr_shift_reg[BSR_LEN-1:1]};
      // id shifts out lsb first; reset state preloads it
      if (state_reg == tap_pkg::ST_RESET) id_shift_reg <= id_hold_reg;
      else if (sel_id && state_reg == tap_pkg::ST_CAP_DR) id_shift_reg <= id_hold_reg;
      else if (sel_id && in_shift_dr)
        id_shift_reg <= {tdi_s, id_shift_reg[tap_pkg::ID_WIDTH-1:1]};
    end
  end

  // update stages latch on the falling test clock edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      instruction  <= tap_pkg::OP_IDCODE;
      bsr_parallel <= '0;
      id_hold_reg  <= '0;
    end else begin
      // held copy never disturbed by shifting
      id_hold_reg <= id_value;
      if (tap_reset || state_reg == tap_pkg::ST_RESET) instruction <= tap_pkg::OP_IDCODE;
      else if (tck_fall && state_reg == tap_pkg::ST_UPD_IR) instruction <= ir_shift_reg;
      if (tck_fall && sel_bsr && state_reg == tap_pkg::ST_UPD_DR) bsr_parallel <= bsr_shift_reg;
    end
  end

  // tdo changes on the falling edge so the tester samples it stably
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      test_data_out    <= 1'b0;
      test_data_out_en <= 1'b0;
      pins_drive_bsr   <= 1'b0;
      pins_highz       <= 1'b0;
    end else begin
      if (tap_reset) test_data_out_en <= 1'b0;
      else if (tck_fall) begin
        test_data_out    <= tdo_next;
        test_data_out_en <= tdo_en_next;
      end
      pins_drive_bsr <= (instruction == tap_pkg::OP_EXTEST) || (instruction == tap_pkg::OP_CLAMP);
      pins_highz     <= (instruction == tap_pkg::OP_HIGHZ);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  reset_state_a: assert property (
    @(posedge clk) disable iff (!resetn) tap_reset |=> state_reg == tap_pkg::ST_RESET)
    else $error("test reset did not force reset state");

  reset_idcode_a: assert property (
    @(posedge clk) disable iff (!resetn) state_reg == tap_pkg::ST_RESET |=> instruction == tap_pkg::OP_IDCODE)
    else $error("reset state did not select idcode");

  ir_capture_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (tck_rise && state_reg == tap_pkg::ST_CAP_IR && !tap_reset) |=> ir_shift_reg[1:0] == 2'h1)
    else $error("ir capture pattern wrong");

  id_fixed_one_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (tck_rise && sel_id && state_reg == tap_pkg::ST_CAP_DR && !tap_reset)
      |=> id_shift_reg[0] == 1'b1)
    else $error("id code lsb not one");

  id_hold_a: assert property (
    @(posedge clk) disable iff (!resetn) in_shift_dr |=> id_hold_reg == $past(id_hold_reg))
    else $error("held id changed while shifting");

  id_shift_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (tck_rise && sel_id && in_shift_dr && !tap_reset)
      |=> id_shift_reg[tap_pkg::ID_WIDTH-2:0] == $past(id_shift_reg[tap_pkg::ID_WIDTH-1:1]))
    else $error("id did not shift lsb first");

  bypass_shift_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (tck_rise && sel_byp && in_shift_dr) |=> bypass_reg == $past(tdi_s))
    else $error("bypass stage missed data in");

  bsr_hold_a: assert property (
    @(posedge clk) disable iff (!resetn)
    !(tck_fall && state_reg == tap_pkg::ST_UPD_DR) |=> bsr_parallel == $past(bsr_parallel))
    else $error("boundary output changed outside update");

  ir_update_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (tck_fall && state_reg == tap_pkg::ST_UPD_IR && !tap_reset) |=> instruction == $past(ir_shift_reg))
    else $error("instruction not latched at update");
endmodule : jtag_test_data_registers

// *** tap_tester.sv ***
`timescale 1ns/1ps
module tap_tester (
  output logic      test_clock,
  output logic      test_mode_select,
  output logic      test_data_in,
  input  wire logic test_data_out,
  input  wire logic test_data_out_en
);
  logic last_tdo;
  initial begin
    test_clock       = 1'b0;
    test_mode_select = 1'b1;
    test_data_in     = 1'b1;
    last_tdo         = 1'b0;
  end
  // ****************************************************************
  // one 125 ns test clock period; clock stands low between steps
  // ****************************************************************
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    // non-blocking drives: the falling edge can land on a system clock edge
    #3.3;
    test_mode_select <= tms;
    test_data_in     <= tdi;
    #59.2;
    // a released output reads as the inverse of its last value
    tdo        = test_data_out_en ? test_data_out : ~last_tdo;
    last_tdo   = tdo;
    test_clock <= 1'b1;
    #62.5;
    test_clock <= 1'b0;
  endtask : step
endmodule : tap_tester

// *** jtag_test_data_registers_tb.sv ***
`timescale 1ns/1ps
module jtag_test_data_registers_tb;
  // identity values are arbitrary
  localparam logic [10:0] MFR   = 11'h2C3;
  localparam logic [15:0] DEV   = 16'hBEEF;
  localparam logic [3:0]  VER   = 4'h5;
  localparam int          BSR   = 8;
  localparam logic [31:0] ID    = {VER, DEV, MFR, 1'b1};
  localparam int          LIMIT = 20000;
  logic           clk, resetn, test_async_reset_n, test_clock, test_mode_select;
  logic           test_data_in, test_data_out, test_data_out_en, pins_drive_bsr, pins_highz;
  logic [BSR-1:0] bsr_capture, bsr_parallel;
  logic [2:0]     instruction;
  int             n_mismatch = 0, samples_checked = 0, cycles = 0;

  jtag_test_data_registers #(.BSR_LEN(BSR), .MFR_CODE(MFR), .DEVICE_CODE(DEV), .VERSION(VER))
  u_jtag_test_data_registers (.clk(clk), .resetn(resetn), .test_clock(test_clock),
    .test_mode_select(test_mode_select), .test_data_in(test_data_in),
    .test_async_reset_n(test_async_reset_n), .test_data_out(test_data_out),
    .test_data_out_en(test_data_out_en), .bsr_capture(bsr_capture),
    .bsr_parallel(bsr_parallel), .instruction(instruction),
    .pins_drive_bsr(pins_drive_bsr), .pins_highz(pins_highz));
  tap_tester u_tap_tester (.test_clock(test_clock), .test_mode_select(test_mode_select),
    .test_data_in(test_data_in), .test_data_out(test_data_out),
    .test_data_out_en(test_data_out_en));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0t timeout", $time);
      stop_test();
    end
  end
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0t %s: saw %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  // from run-test-idle, scan n bits lsb first and return to idle
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
                      output logic [31:0] dout);
    logic tdo;
    dout = '0;
    u_tap_tester.step(1'b1, 1'b0, tdo);
    if (ir) u_tap_tester.step(1'b1, 1'b0, tdo);
    u_tap_tester.step(1'b0, 1'b0, tdo);
    u_tap_tester.step(1'b0, 1'b0, tdo);
    for (int i = 0; i < n; i++) begin
      u_tap_tester.step(i == n - 1, din[i], tdo);
      dout[i] = tdo;
    end
    u_tap_tester.step(1'b1, 1'b0, tdo);
    u_tap_tester.step(1'b0, 1'b0, tdo);
  endtask : scan
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_idcode();
    logic        tdo;
    logic [31:0] dout;
    check(32'(instruction), 32'(tap_pkg::OP_IDCODE), "reset instruction");
    u_tap_tester.step(1'b0, 1'b0, tdo);
    scan(1'b0, 32'h0, 32, dout);
    check(dout, ID, "id code");
    $display("test idcode done");
  endtask : t_idcode
  task automatic t_ir_bypass();
    logic [31:0] dout;
    scan(1'b1, 32'h7, 3, dout);
    check(dout, 32'h1, "ir capture");
    check(32'(instruction), 32'(tap_pkg::OP_BYPASS), "bypass loaded");
    scan(1'b0, 32'hD, 4, dout);
    check(dout, 32'hA, "bypass path");
    $display("test ir bypass done");
  endtask : t_ir_bypass
  task automatic t_opcodes();
    logic [31:0] dout;
    logic [2:0]  ops [8] = '{tap_pkg::OP_EXTEST, tap_pkg::OP_IDCODE, tap_pkg::OP_SAMPLE,
      tap_pkg::OP_CLAMP, tap_pkg::OP_HIGHZ, 3'h5, 3'h6, tap_pkg::OP_BYPASS};
    foreach (ops[k]) begin
      scan(1'b1, 32'(ops[k]), 3, dout);
      check(32'(instruction), 32'(ops[k]), "instruction");
      check(32'(pins_drive_bsr), 32'(ops[k] == 3'h0 || ops[k] == 3'h3), "drive");
      check(32'(pins_highz), 32'(ops[k] == 3'h4), "highz");
      if (ops[k] == 3'h0 || ops[k] == 3'h2) begin
        @(posedge clk);
        bsr_capture <= 8'hA5 ^ {5'h0, ops[k]};
        scan(1'b0, 32'(8'h3C ^ {5'h0, ops[k]}), BSR, dout);
        check(dout, 32'(8'hA5 ^ {5'h0, ops[k]}), "bsr capture");
        check(32'(bsr_parallel), 32'(8'h3C ^ {5'h0, ops[k]}), "bsr latch");
      end else if (ops[k] == 3'h1) begin
        scan(1'b0, 32'h0, 32, dout);
        check(dout, ID, "id again");
      end else begin
        scan(1'b0, 32'h3, 4, dout);
        check(dout, 32'h6, "one-bit path");
      end
    end
    $display("test opcodes done");
  endtask : t_opcodes
  task automatic t_async_reset();
    logic        tdo;
    logic [31:0] dout;
    scan(1'b1, 32'h7, 3, dout);
    u_tap_tester.step(1'b1, 1'b0, tdo);
    u_tap_tester.step(1'b0, 1'b0, tdo);
    u_tap_tester.step(1'b0, 1'b0, tdo);
    u_tap_tester.step(1'b0, 1'b1, tdo);
    @(posedge clk);
    test_async_reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    check(32'(test_data_out_en), 32'h0, "scan abandoned");
    check(32'(instruction), 32'(tap_pkg::OP_IDCODE), "reset to id");
    test_async_reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_idcode();
    scan(1'b1, 32'h7, 3, dout);
    repeat (5) u_tap_tester.step(1'b1, 1'b0, tdo);
    check(32'(instruction), 32'(tap_pkg::OP_IDCODE), "mode select reset");
    $display("test async reset done");
  endtask : t_async_reset
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    resetn             = 1'b0;
    test_async_reset_n = 1'b1;
    bsr_capture        = '0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    t_idcode();
    t_ir_bypass();
    t_opcodes();
    t_async_reset();
    stop_test();
  end
endmodule : jtag_test_data_registers_tb
